// >>> hw/two_wire_host_request_status.sv
// Register access over APB was decided locally.
`timescale 1ns/10ps
// Contract
// - protocol select uses send/receive byte forms
// - protocol select skips the index byte
// - control/status bit 6 reads zero
// - target address write launches, sets busy
// - busy clears after read, data valid
// - autoload busy high during eeprom load
// - bus present captured from clock pull-up
// - normal 100 kHz, test bit speeds up
// - request error set on missing acknowledge
// - writing one clears request error
// - autoload error on nack or format
// - writing one clears autoload error
// - sticky bits not cleared by function reset
// - target bit 0 direction, 7..1 address
// - index register gives the byte address
// - data register sends and receives byte
module two_wire_host_request_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic function_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [two_wire_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_oe,
  output logic sda_out,
  output logic [two_wire_pkg::AUTO_BYTES*8-1:0] autoload_defaults
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: {sda, scl}
  logic [1:0] pin_s1, pin_s2, pin_s3, pin_f;
  wire scl_f = pin_f[0];
  wire sda_f = pin_f[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_s3 <= 2'h0;
      pin_f <= 2'h0;
    end else begin
      pin_s1 <= {sda_in, scl_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic [7:0] byte_buffer, byte_index, target_address;
  logic short_protocol_select, bus_present_flag, fast_clock_test, req_err, auto_err;
  logic host_request_busy, autoload_busy;
  logic [two_wire_pkg::IRQ_W-1:0] irq_status, irq_mask;

  wire access = psel && penable;
  wire hit_buf = paddr == two_wire_pkg::ADDR_BYTE_BUFFER;
  wire hit_idx = paddr == two_wire_pkg::ADDR_BYTE_INDEX;
  wire hit_tgt = paddr == two_wire_pkg::ADDR_TARGET_ADDRESS;
  wire hit_ctl = paddr == two_wire_pkg::ADDR_CONTROL_STATUS;
  wire hit_ist = paddr == two_wire_pkg::ADDR_IRQ_STATUS;
  wire hit_imk = paddr == two_wire_pkg::ADDR_IRQ_MASK;
  wire mapped = hit_buf | hit_idx | hit_tgt | hit_ctl | hit_ist | hit_imk;
  // only the low byte lane carries register data
  wire wr = access && pwrite && mapped && pstrb[0];
  wire wr_ctl = wr && hit_ctl;
  wire [7:0] ctl_read = {short_protocol_select, 1'b0, host_request_busy, autoload_busy,
                         bus_present_flag, fast_clock_test, req_err, auto_err};
  wire [7:0] rd_byte = hit_buf ? byte_buffer :
                       hit_idx ? byte_index :
                       hit_tgt ? target_address :
                       hit_ctl ? ctl_read :
                       hit_ist ? {4'h0, irq_status} :
                       hit_imk ? {4'h0, irq_mask} : 8'h00;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // read data is sampled in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= {24'h0, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // job selection and step table
  two_wire_pkg::engine_state_e eng_state;
  logic [2:0] step;
  logic [1:0] qph;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic job_err, job_is_auto, job_dir, job_short, host_wait, auto_wait, tick;
  logic [6:0] job_addr;
  logic [7:0] job_index, job_data;
  logic [1:0] auto_count;

  function automatic logic [4:0] op_of(input logic short_p, input logic read_p, input logic [2:0] s);
    logic [4:0] r;
    r = two_wire_pkg::STEP_STOP;
    case ({short_p, read_p})
      2'b00: r = (s == 3'h0) ? two_wire_pkg::STEP_START :
                 (s == 3'h1) ? two_wire_pkg::STEP_TX_ADDR_W :
                 (s == 3'h2) ? two_wire_pkg::STEP_TX_INDEX :
                 (s == 3'h3) ? two_wire_pkg::STEP_TX_DATA : two_wire_pkg::STEP_STOP;
      2'b01: r = (s == 3'h0 || s == 3'h3) ? two_wire_pkg::STEP_START :
                 (s == 3'h1) ? two_wire_pkg::STEP_TX_ADDR_W :
                 (s == 3'h2) ? two_wire_pkg::STEP_TX_INDEX :
                 (s == 3'h4) ? two_wire_pkg::STEP_TX_ADDR_R :
                 (s == 3'h5) ? two_wire_pkg::STEP_RX : two_wire_pkg::STEP_STOP;
      2'b10: r = (s == 3'h0) ? two_wire_pkg::STEP_START :
                 (s == 3'h1) ? two_wire_pkg::STEP_TX_ADDR_W :
                 (s == 3'h2) ? two_wire_pkg::STEP_TX_DATA : two_wire_pkg::STEP_STOP;
      default: r = (s == 3'h0) ? two_wire_pkg::STEP_START :
                   (s == 3'h1) ? two_wire_pkg::STEP_TX_ADDR_R :
                   (s == 3'h2) ? two_wire_pkg::STEP_RX : two_wire_pkg::STEP_STOP;
    endcase
    return r;
  endfunction

  wire [4:0] cur = op_of(job_short, job_dir, step);
  wire [4:0] nxt = op_of(job_short, job_dir, step + 3'h1);
  wire cur_rx = cur[2];
  wire [7:0] nxt_byte = (nxt[1:0] == two_wire_pkg::SRC_ADDR_W) ? {job_addr, 1'b0} :
                        (nxt[1:0] == two_wire_pkg::SRC_ADDR_R) ? {job_addr, 1'b1} :
                        (nxt[1:0] == two_wire_pkg::SRC_INDEX) ? job_index : job_data;
  wire idle = eng_state == two_wire_pkg::ENG_IDLE;
  wire launch_auto = idle && auto_wait;
  wire launch_host = idle && host_wait && !autoload_busy;
  wire launch = launch_auto || launch_host;
  wire ack_bit = bitcnt == two_wire_pkg::ACK_BIT;
  wire q_end = tick && qph == 2'h3;
  wire job_done = q_end && eng_state == two_wire_pkg::ENG_STOP;
  wire rx_done = q_end && eng_state == two_wire_pkg::ENG_XFER && ack_bit && cur_rx;
  wire marker_bad = auto_count == 2'h0 && shreg != two_wire_pkg::AUTO_MARKER;
  wire auto_fail = job_done && job_is_auto && (job_err || marker_bad);
  wire auto_ok = job_done && job_is_auto && !auto_fail;
  wire host_done = job_done && !job_is_auto;
  wire tgt_accept = wr && hit_tgt && !host_request_busy;

  bit_clock_divider divider (
    .pclk(pclk),
    .presetn(presetn),
    .run(!idle),
    .last(fast_clock_test ? two_wire_pkg::QUARTER_TEST_LAST : two_wire_pkg::QUARTER_NORMAL_LAST),
    .tick(tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      job_is_auto <= 1'b0;
      job_dir <= 1'b0;
      job_short <= 1'b0;
      job_addr <= 7'h0;
      job_index <= 8'h00;
      job_data <= 8'h00;
    end else if (launch) begin
      job_is_auto <= launch_auto;
      job_dir <= launch_auto ? 1'b1 : target_address[0];
      job_short <= launch_auto ? 1'b0 : short_protocol_select;
      job_addr <= launch_auto ? two_wire_pkg::AUTO_DEVICE : target_address[7:1];
      job_index <= launch_auto ? {6'h0, auto_count} : byte_index;
      job_data <= byte_buffer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit engine: four quarter phases per bit, scl follows the divider only
  // no clock stretching: a slave holding scl low is not waited for
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_state <= two_wire_pkg::ENG_IDLE;
      step <= 3'h0;
      qph <= 2'h0;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      job_err <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (function_reset) begin
      eng_state <= two_wire_pkg::ENG_IDLE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      qph <= 2'h0;
    end else if (idle) begin
      if (launch) begin
        eng_state <= two_wire_pkg::ENG_START;
        step <= 3'h0;
        qph <= 2'h0;
        job_err <= 1'b0;
      end
    end else if (tick) begin
      qph <= qph + 2'h1;
      unique case (eng_state)
        two_wire_pkg::ENG_START: begin
          if (qph == 2'h0) sda_oe <= 1'b0;
          if (qph == 2'h1) scl_oe <= 1'b0;
          if (qph == 2'h2) sda_oe <= 1'b1;
        end
        two_wire_pkg::ENG_XFER: begin
          if (qph == 2'h0) sda_oe <= !(ack_bit || cur_rx) && !shreg[7];
          if (qph == 2'h1) scl_oe <= 1'b0;
          if (qph == 2'h2 && !ack_bit) shreg <= {shreg[6:0], sda_f};
          if (qph == 2'h2 && ack_bit && !cur_rx && sda_f) job_err <= 1'b1;
          if (qph == 2'h3 && !ack_bit) bitcnt <= bitcnt + 4'h1;
        end
        two_wire_pkg::ENG_STOP: begin
          if (qph == 2'h0) sda_oe <= 1'b1;
          if (qph == 2'h1) scl_oe <= 1'b0;
          if (qph == 2'h2) sda_oe <= 1'b0;
          if (qph == 2'h3) eng_state <= two_wire_pkg::ENG_IDLE;
        end
        default: eng_state <= two_wire_pkg::ENG_IDLE;
      endcase
      if (qph == 2'h3 && eng_state != two_wire_pkg::ENG_STOP) begin
        scl_oe <= 1'b1;
        if (eng_state == two_wire_pkg::ENG_XFER && ack_bit && job_err) begin
          eng_state <= two_wire_pkg::ENG_STOP;
        end else if (eng_state == two_wire_pkg::ENG_START || ack_bit) begin
          step <= step + 3'h1;
          eng_state <= two_wire_pkg::engine_state_e'(nxt[4:3]);
          // keep the received byte through stop: autoload and read checks use it at job end
          if (nxt[4:3] == two_wire_pkg::ENG_XFER) shreg <= nxt_byte;
          bitcnt <= 4'h0;
        end
      end
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // detection and autoload sequencing
  logic [2:0] settle;
  logic detect_done;
  wire detect_fire = !detect_done && settle == two_wire_pkg::DETECT_SETTLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle <= 3'h0;
      detect_done <= 1'b0;
      autoload_busy <= 1'b0;
      auto_wait <= 1'b0;
      auto_count <= 2'h0;
      autoload_defaults <= '0;
    end else if (function_reset) begin
      autoload_busy <= 1'b0;
      auto_wait <= 1'b0;
    end else if (detect_fire) begin
      detect_done <= 1'b1;
      autoload_busy <= scl_f;
      auto_wait <= scl_f;
    end else begin
      if (!detect_done) settle <= settle + 3'h1;
      if (launch_auto) auto_wait <= 1'b0;
      if (auto_fail) autoload_busy <= 1'b0;
      if (auto_ok) begin
        autoload_defaults[auto_count*8 +: 8] <= shreg;
        autoload_busy <= auto_count != two_wire_pkg::AUTO_LAST;
        auto_wait <= auto_count != two_wire_pkg::AUTO_LAST;
        auto_count <= auto_count + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers; the sticky bits ignore function_reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_buffer <= two_wire_pkg::REG_RESET;
      byte_index <= two_wire_pkg::REG_RESET;
      target_address <= two_wire_pkg::REG_RESET;
      short_protocol_select <= 1'b0;
      bus_present_flag <= 1'b0;
      fast_clock_test <= 1'b0;
      req_err <= 1'b0;
      auto_err <= 1'b0;
    end else begin
      // received byte wins over a software write in the same cycle
      if (rx_done && !job_is_auto) byte_buffer <= shreg;
      else if (wr && hit_buf) byte_buffer <= pwdata[7:0];
      if (wr && hit_idx) byte_index <= pwdata[7:0];
      if (tgt_accept) target_address <= pwdata[7:0];
      if (wr_ctl) short_protocol_select <= pwdata[two_wire_pkg::BIT_SHORT];
      if (wr_ctl) fast_clock_test <= pwdata[two_wire_pkg::BIT_FAST];
      if (detect_fire) bus_present_flag <= scl_f;
      else if (wr_ctl) bus_present_flag <= pwdata[two_wire_pkg::BIT_PRESENT];
      if (host_done && job_err) req_err <= 1'b1;
      else if (wr_ctl && pwdata[two_wire_pkg::BIT_REQ_ERR]) req_err <= 1'b0;
      if (auto_fail) auto_err <= 1'b1;
      else if (wr_ctl && pwdata[two_wire_pkg::BIT_AUTO_ERR]) auto_err <= 1'b0;
    end
  end

  // busy set only by an accepted target write, never by a control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_request_busy <= 1'b0;
      host_wait <= 1'b0;
    end else if (function_reset) begin
      host_request_busy <= 1'b0;
      host_wait <= 1'b0;
    end else begin
      if (tgt_accept) host_request_busy <= 1'b1;
      else if (host_done) host_request_busy <= 1'b0;
      if (tgt_accept) host_wait <= 1'b1;
      else if (launch_host) host_wait <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: write one to clear, a new event wins
  wire [two_wire_pkg::IRQ_W-1:0] irq_events = {auto_fail, auto_ok && auto_count == two_wire_pkg::AUTO_LAST,
                                               host_done && job_err, host_done};
  wire [two_wire_pkg::IRQ_W-1:0] irq_clear = (wr && hit_ist) ? pwdata[two_wire_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else if (function_reset) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      if (wr && hit_imk) irq_mask <= pwdata[two_wire_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_busy_set;
    tgt_accept && !function_reset |=> host_request_busy && host_wait;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set by target write");

  property p_rsvd_zero;
    access && !pwrite && hit_ctl |-> prdata[6] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read nonzero");

  property p_short_no_index;
    eng_state == two_wire_pkg::ENG_XFER && job_short |-> cur != two_wire_pkg::STEP_TX_INDEX;
  endproperty
  a_short_no_index: assert property (p_short_no_index) else $error("index sent in short mode");

  property p_short_read;
    eng_state == two_wire_pkg::ENG_XFER && job_short && job_dir && step == 3'h1 && bitcnt == 4'h0 && qph != 2'h3
      |-> shreg[0];
  endproperty
  a_short_read: assert property (p_short_read) else $error("short read address not read form");

  property p_req_err;
    host_done && job_err && !function_reset |=> req_err && !host_request_busy;
  endproperty
  a_req_err: assert property (p_req_err) else $error("request error not flagged");

  property p_req_clear;
    wr_ctl && pwdata[two_wire_pkg::BIT_REQ_ERR] && !(host_done && job_err) |=> !req_err;
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request error not cleared");

  property p_auto_hold;
    auto_err && !(wr_ctl && pwdata[two_wire_pkg::BIT_AUTO_ERR]) |=> auto_err;
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("autoload error lost");

  property p_read_valid;
    host_done && job_dir && !job_err |-> byte_buffer == shreg ##1 !host_request_busy;
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("read byte not valid at busy clear");

  property p_rate;
    tick && !fast_clock_test && !function_reset |=> !tick [*8];
  endproperty
  a_rate: assert property (p_rate) else $error("bus clock too fast");

  property p_ro_busy;
    wr_ctl && !autoload_busy && !detect_fire |=> !autoload_busy;
  endproperty
  a_ro_busy: assert property (p_ro_busy) else $error("autoload busy written by software");

endmodule

// >>> pkg/two_wire_pkg.sv
package two_wire_pkg;

  // clock and bus rates
  localparam int CLK_HZ = 20000000;
  localparam int BUS_HZ = 100000;
  localparam int TEST_BUS_HZ = 400000;
  localparam int QUARTERS_PER_BIT = 4;
  localparam int DIV_W = 6;
  // quarter-bit periods, rounded down so the bus never runs slower than nominal
  localparam int QUARTER_NORMAL = CLK_HZ / (BUS_HZ * QUARTERS_PER_BIT);
  localparam int QUARTER_TEST = CLK_HZ / (TEST_BUS_HZ * QUARTERS_PER_BIT);
  localparam logic [DIV_W-1:0] QUARTER_NORMAL_LAST = DIV_W'(QUARTER_NORMAL - 1);
  localparam logic [DIV_W-1:0] QUARTER_TEST_LAST = DIV_W'(QUARTER_TEST - 1);

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_BYTE_BUFFER = 8'hb0;
  localparam logic [7:0] IDX_BYTE_INDEX = 8'hb1;
  localparam logic [7:0] IDX_TARGET_ADDRESS = 8'hb2;
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'hb3;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hb4;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hb5;
  localparam logic [ADDR_W-1:0] ADDR_BYTE_BUFFER = {2'h0, IDX_BYTE_BUFFER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_BYTE_INDEX = {2'h0, IDX_BYTE_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_TARGET_ADDRESS = {2'h0, IDX_TARGET_ADDRESS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_STATUS = {2'h0, IDX_CONTROL_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
  localparam logic [7:0] REG_RESET = 8'h00;

  // control/status field positions
  localparam int BIT_SHORT = 7;
  localparam int BIT_BUSY = 5;
  localparam int BIT_AUTO_BUSY = 4;
  localparam int BIT_PRESENT = 3;
  localparam int BIT_FAST = 2;
  localparam int BIT_REQ_ERR = 1;
  localparam int BIT_AUTO_ERR = 0;

  // interrupt status / mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_REQ_DONE = 0;
  localparam int IRQ_REQ_ERR = 1;
  localparam int IRQ_AUTO_DONE = 2;
  localparam int IRQ_AUTO_ERR = 3;

  ////////////////////////////////////////////////////////////////////////////
  // autoload
  localparam int AUTO_BYTES = 4;
  localparam logic [1:0] AUTO_LAST = 2'(AUTO_BYTES - 1);
  localparam logic [6:0] AUTO_DEVICE = 7'h50;
  localparam logic [7:0] AUTO_MARKER = 8'ha5;
  localparam logic [2:0] DETECT_SETTLE = 3'h6;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_START = 2'b01,
    ENG_XFER = 2'b10,
    ENG_STOP = 2'b11
  } engine_state_e;

  // step code: {engine state, receive, byte source}
  localparam logic [1:0] SRC_ADDR_W = 2'h0;
  localparam logic [1:0] SRC_ADDR_R = 2'h1;
  localparam logic [1:0] SRC_INDEX = 2'h2;
  localparam logic [1:0] SRC_DATA = 2'h3;
  localparam logic [4:0] STEP_START = 5'h08;
  localparam logic [4:0] STEP_TX_ADDR_W = 5'h10;
  localparam logic [4:0] STEP_TX_ADDR_R = 5'h11;
  localparam logic [4:0] STEP_TX_INDEX = 5'h12;
  localparam logic [4:0] STEP_TX_DATA = 5'h13;
  localparam logic [4:0] STEP_RX = 5'h14;
  localparam logic [4:0] STEP_STOP = 5'h18;

endpackage

// >>> hw/bit_clock_divider.sv
`timescale 1ns/10ps
module bit_clock_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [two_wire_pkg::DIV_W-1:0] last,
  output logic tick
);

  logic [two_wire_pkg::DIV_W-1:0] count;

  assign tick = run && (count >= last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (!run || tick) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule

// >>> sim/eeprom_model.sv
`timescale 1ns/10ps
module eeprom_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  logic [7:0] mem [256];
  logic [7:0] sh, tx, idx;
  logic rd, tx_on;
  int cnt, ph, nbytes;
  initial begin
    pull = 0; cnt = 0; ph = 0; rd = 0; tx_on = 0; idx = 0; nbytes = 0;
    for (int k = 0; k < 256; k++) mem[k] = 8'(k) ^ 8'h3c;
  end
  ////////////////////////////////////////////////////////////////////////////
  // a repeated start also lands here, so byte counts are per segment
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = -1; ph = 0; rd = 0; tx_on = 0; nbytes = 0;
  end
  always @(posedge scl) sh = {sh[6:0], sda};
  always @(negedge scl) begin
    cnt++;
    if (cnt == 8 && tx_on) pull = 0;
    else if (cnt == 8) begin
      nbytes++;
      if (ph == 0) begin
        rd = sh[0];
        pull = (sh[7:1] == DEV);
        ph = pull ? 1 : 3;
      end else if (ph == 1) begin
        idx = sh;
        ph = 2; pull = 1;
      end else if (ph == 2) begin
        mem[idx] = sh;
        idx++; pull = 1;
      end else pull = 0;
    end else if (cnt == 9) begin
      cnt = 0; pull = 0;
      if (rd && !tx_on && ph == 1) begin
        tx = mem[idx]; idx++; tx_on = 1; pull = !tx[7];
      end else tx_on = 0;
    end else if (tx_on) pull = !tx[7-cnt];
  end
endmodule

// >>> sim/two_wire_host_request_status_tb.sv
`timescale 1ns/10ps
module two_wire_host_request_status_tb;
  localparam logic [11:0] CS = two_wire_pkg::ADDR_CONTROL_STATUS;
  localparam logic [11:0] IS = two_wire_pkg::ADDR_IRQ_STATUS;
  localparam logic [11:0] TA = two_wire_pkg::ADDR_TARGET_ADDRESS;
  localparam logic [11:0] BB = two_wire_pkg::ADDR_BYTE_BUFFER;
  logic pclk, presetn, function_reset, psel, penable, pwrite, no_pullup, pull, chk_on;
  logic pready, pslverr, irq, scl_oe, sda_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, auto_val, exp_auto;
  logic [33:0] expq [$];
  logic [31:0] lfsr = 32'd72320;
  logic [7:0] d, v;
  int fails = 0, n_tests = 0;
  time t0 = 0, per = 0;
  wire scl = !scl_oe && !no_pullup;
  wire sda = !(sda_oe || pull);
  two_wire_host_request_status two_wire_host_request_status_i (.pclk(pclk), .presetn(presetn),
    .function_reset(function_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_oe(sda_oe), .sda_out(),
    .autoload_defaults(auto_val));
  eeprom_model eeprom_model_i (.scl(scl), .sda(sda), .pull(pull));
  ////////////////////////////////////////////////////////////////////////////
  function logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // read expectations go through the queue so the monitor judges them
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] wd, input logic c, input logic [33:0] e);
    if (c) expq.push_back(e);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, wd}; chk_on <= c;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    v = prdata[7:0];
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] wd); xfer(1, a, wd, 0, 0); endtask
  task rd(input logic [11:0] a, input logic [33:0] e); xfer(0, a, 0, 1, e); endtask
  task poll(input int b);
    int k;
    for (k = 0; k < 20000; k++) begin
      xfer(0, CS, 0, 0, 0);
      if (v[b] === 1'b0) break;
    end
    if (k == 20000) begin fails++; $display("mismatch at %0t: flag stuck", $time); end
  endtask
  task do_reset;
    presetn <= 0; repeat (12) @(posedge pclk); presetn <= 1; repeat (10) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin pclk = 0; forever #25 pclk = ~pclk; end
  always @(posedge scl) begin per = $time - t0; t0 = $time; end
  always @(negedge pclk) if (psel && penable && !pwrite && chk_on === 1'b1)
    check({irq, pslverr, prdata}, expq.pop_front());
  initial begin #4000000; fails++; end_of_test; end
  initial begin
    presetn = 0; function_reset = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    chk_on = 0; no_pullup = 0;
    #1;
    for (int k = 0; k < 4; k++) exp_auto[8*k +: 8] = k == 0 ? 8'ha5 : rnd();
    for (int k = 0; k < 4; k++) eeprom_model_i.mem[k] = exp_auto[8*k +: 8];
    do_reset;
    rd(CS, 34'h18);
    poll(4);
    check(34'(auto_val), 34'(exp_auto));
    check(34'(per), 34'(4 * two_wire_pkg::QUARTER_NORMAL * 50));
    rd(CS, 34'h08);
    rd(IS, 34'h04);
    wr(two_wire_pkg::ADDR_IRQ_MASK, 8'h0f);
    rd(IS, 34'h200000004);
    wr(IS, 8'h04);
    rd(IS, 34'h0);
    wr(CS, 8'hff);
    rd(CS, 34'h8c);
    wr(CS, 8'h0c);
    d = rnd();
    wr(BB, d); wr(two_wire_pkg::ADDR_BYTE_INDEX, 8'h40); wr(TA, {7'h50, 1'b0});
    rd(CS, 34'h2c);
    poll(5);
    check(34'(eeprom_model_i.mem[8'h40]), 34'(d));
    check(34'(eeprom_model_i.nbytes), 34'd3);
    check(34'(per), 34'(4 * two_wire_pkg::QUARTER_TEST * 50));
    rd(IS, 34'h200000001);
    wr(BB, 8'h00); wr(TA, {7'h50, 1'b1});
    poll(5);
    rd(BB, 34'h200000000 | 34'(d));
    // short forms: the second byte lands in the model as its index
    wr(CS, 8'h8c); d = rnd(); wr(BB, d); wr(TA, {7'h50, 1'b0}); poll(5);
    check(34'(eeprom_model_i.nbytes), 34'd2);
    wr(TA, {7'h50, 1'b1}); poll(5);
    check(34'(eeprom_model_i.nbytes), 34'd1);
    rd(BB, 34'h200000000 | 34'(eeprom_model_i.mem[d]));
    wr(IS, 8'h0f);
    wr(TA, {7'h33, 1'b0}); poll(5);
    rd(CS, 34'h20000008e);
    @(posedge pclk) function_reset <= 1;
    @(posedge pclk) function_reset <= 0;
    rd(CS, 34'h8e);
    wr(CS, 8'h0c); rd(CS, 34'h0e);
    wr(CS, 8'h0e); rd(CS, 34'h0c);
    rd(12'h000, 34'h100000000);
    eeprom_model_i.mem[0] = 8'h5a;
    do_reset; poll(4);
    rd(CS, 34'h09);
    wr(CS, 8'h08); rd(CS, 34'h09);
    wr(CS, 8'h09); rd(CS, 34'h08);
    no_pullup <= 1;
    do_reset;
    rd(CS, 34'h00);
    end_of_test;
  end
endmodule
